// ### rtl/type_detect_pkg.sv
// Shared constants and carriers for the processor interface selector.
// Assumes a single 250 MHz core clock and voltages carried in 0.1 mV units.
package type_detect_pkg;
	localparam int CODE_W = 6;
	localparam int VREF_W = 15;
	localparam int CLK_MHZ = 250;
	// Voltages in units of 0.1 mV
	localparam logic [14:0] HI_BASE_UV = 15'h3C8C; // 1.5500 V
	localparam logic [14:0] HI_STEP_UV = 15'h00FA; // 25 mV
	localparam logic [14:0] LO_BASE_UV = 15'h1DC9; // 0.7625 V
	localparam logic [14:0] LO_STEP_UV = 15'h007D; // 12.5 mV
	localparam logic [14:0] FIX_V0 = 15'h36B0; // 1.4 V
	localparam logic [14:0] FIX_V1 = 15'h2EE0; // 1.2 V
	localparam logic [14:0] FIX_V2 = 15'h2710; // 1.0 V
	localparam logic [14:0] FIX_V3 = 15'h1F40; // 0.8 V
	localparam int CODE_MSB = 5;
	localparam int TYPE_BIT = 1;
	localparam int SCL_BIT = 3;
	localparam int SDA_BIT = 2;
	localparam int LPF_BIT = 7;
	localparam logic [2:0] PH_MIN = 3'h2;
	localparam logic [2:0] PH_MAX = 3'h4;
	localparam logic [2:0] PH_LOW = 3'h1;
	localparam logic [2:0] PH_RESET = 3'h4;
	localparam logic [1:0] NORTH_SHIFT_RESET = 2'h1;
	localparam logic [7:0] SERIAL_BYTE_RESET = 8'hFF;

	typedef enum logic [1:0] {
		MODE_IDLE = 2'b00,
		MODE_PAR = 2'b01,
		MODE_SER = 2'b10,
		MODE_FIX = 2'b11
	} if_mode_t;

	typedef struct packed {
		logic hs_on;
		logic ls_on;
		logic switching;
		logic [1:0] phase_slot;
	} north_drive_t;
endpackage

// ### rtl/pin_sync3.sv
// Three-stage input synchroniser for a bus of asynchronous pins.
// Assumes inputs arrive from outside the core clock domain.
`timescale 1ns/1ns
module pin_sync3 #(
	parameter int W = 1
) (
	input wire logic core_clk, // Core clock
	input wire logic rst_b, // Synchronous reset, active low
	input wire logic [W-1:0] pin_in, // Raw pins
	output logic [W-1:0] pin_out // Filtered level
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] out_r;
	wire logic [W-1:0] agree = ~(s2_r ^ s3_r);

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			out_r <= '0;
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			out_r <= (agree & s3_r) | (~agree & out_r);
		end
	end

	assign pin_out = out_r;
endmodule // pin_sync3

// ### rtl/cpu_type_detect.sv
// Processor interface selector and parallel code to core reference decoder.
// Assumes pins are asynchronous; serial bytes arrive from a separate receiver
// on the core clock with a one-cycle valid strobe.
//
// Overview of operation
// - Enable rise samples bit 1: 1 parallel.
// - Parallel mode: northbridge switches off, idle.
// - Serial mode: bits 2,3 bus; others ignored.
// - Parallel mode decodes all six code lines.
// - Parallel mode core reference follows table.
// - Codes 0-31: 1.55 V down 25 mV.
// - Codes 32-63: 0.7625 V down 12.5 mV.
// - Parallel mode ignores power ok input.
// - Parallel start-up soft-starts regardless of power ok.
// - Parallel code sampled continuously, updated on change.
// - Fixed mode: serial lines select four voltages.
// - Fixed levels 1.4, 1.2, 1.0, 0.8 V.
// - Low-power flag reduces active core phases.
// - Flag active low in serial byte bit 7.
// - Northbridge single phase; core two to four phases.
// - Enabled northbridge phase shifted from core phases outside low power.
// - Shedding adjusts phase count by load when enabled.
// - Offset, frequency, overvoltage changeable while running.
`timescale 1ns/1ns
module cpu_type_detect
	import type_detect_pkg::*;
#(
	parameter int SS_STEPS = 64
) (
	input wire logic core_clk, // Core clock, 250 MHz
	input wire logic rst_b, // Synchronous reset, active low
	input wire logic enable_pin, // Controller enable pin
	input wire logic fix_mode_pin, // Fixed-voltage debug strap level
	input wire logic [CODE_W-1:0] voltage_code_bus, // Code lines, bit 5 MSB
	input wire logic power_ok_input, // Power ok pin
	input wire logic [7:0] serial_byte, // Received serial data byte
	input wire logic serial_byte_valid, // One-cycle strobe with serial_byte
	input wire logic serial_core_addr, // Byte addresses the core plane
	input wire logic serial_north_addr, // Byte addresses the northbridge plane
	input wire logic [2:0] core_phase_cfg, // Programmed core phase count
	input wire logic dynamic_phase_shedding, // Shedding enable from management bus
	input wire logic [2:0] load_phase_need, // Phases the load current needs
	input wire logic [VREF_W-1:0] offset_cfg, // Voltage offset, 0.1 mV units
	input wire logic [7:0] freq_cfg, // Switching frequency setting
	input wire logic [7:0] ovp_cfg, // Overvoltage threshold setting
	output logic [1:0] if_mode, // Latched interface mode
	output logic [VREF_W-1:0] core_vref, // Core reference, 0.1 mV units
	output logic [VREF_W-1:0] north_vref, // Northbridge reference
	output logic core_ss_active, // Core soft-start in progress
	output logic code_changed, // Pulse: parallel code changed
	output logic serial_scl, // Synchronised serial clock line
	output logic serial_data_line, // Synchronised serial data line
	output logic serial_en, // Serial receiver may run
	output logic serial_cmd_en, // Serial commands honoured
	output north_drive_t north_drive, // Northbridge switch controls
	output logic [2:0] core_phases, // Active core phase count
	output logic low_power_active, // Low-power state in force
	output logic [7:0] freq_out, // Applied switching frequency
	output logic [7:0] ovp_out // Applied overvoltage threshold
);
	////////////////////////////////////////////////////////////////////////
	// Input synchronisation

	localparam int SYNC_W = CODE_W + 3;
	wire logic [SYNC_W-1:0] raw_pins = {fix_mode_pin, power_ok_input, enable_pin,
		voltage_code_bus};
	wire logic [SYNC_W-1:0] sync_pins;

	pin_sync3 #(.W(SYNC_W)) u_sync (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.pin_in(raw_pins),
		.pin_out(sync_pins)
	);

	wire logic [CODE_W-1:0] code_s = sync_pins[CODE_W-1:0];
	wire logic en_s = sync_pins[CODE_W];
	wire logic pok_s = sync_pins[CODE_W+1];
	wire logic fix_s = sync_pins[CODE_W+2];
	wire logic code_bit1_type_select = code_s[TYPE_BIT];

	////////////////////////////////////////////////////////////////////////
	// Decoding functions

	function automatic logic [VREF_W-1:0] par_code_volt(input logic [CODE_W-1:0] c);
		logic [VREF_W-1:0] idx;
		idx = {{(VREF_W-5){1'b0}}, c[4:0]};
		if (!c[CODE_MSB])
			par_code_volt = VREF_W'(HI_BASE_UV - idx * HI_STEP_UV);
		else
			par_code_volt = VREF_W'(LO_BASE_UV - idx * LO_STEP_UV);
	endfunction

	function automatic logic [VREF_W-1:0] fix_volt(input logic [1:0] sel);
		case (sel)
			2'b00: fix_volt = FIX_V0;
			2'b01: fix_volt = FIX_V1;
			2'b10: fix_volt = FIX_V2;
			default: fix_volt = FIX_V3;
		endcase
	endfunction

	function automatic logic [2:0] clamp_ph(input logic [2:0] p);
		if (p < PH_MIN)
			clamp_ph = PH_MIN;
		else if (p > PH_MAX)
			clamp_ph = PH_MAX;
		else
			clamp_ph = p;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Mode detection

	logic en_d_r;
	if_mode_t mode_r;
	if_mode_t mode_nxt;
	wire logic en_rise = en_s & ~en_d_r;

	always_comb begin
		mode_nxt = mode_r;
		if (!en_s)
			mode_nxt = MODE_IDLE;
		else if (en_rise) begin
			if (code_bit1_type_select)
				mode_nxt = MODE_PAR;
			else if (fix_s)
				mode_nxt = MODE_FIX;
			else
				mode_nxt = MODE_SER;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			en_d_r <= 1'b0;
			mode_r <= MODE_IDLE;
		end else begin
			en_d_r <= en_s;
			mode_r <= mode_nxt;
		end
	end

	wire logic is_par = (mode_r == MODE_PAR);
	wire logic is_ser = (mode_r == MODE_SER);
	wire logic is_fix = (mode_r == MODE_FIX);

	////////////////////////////////////////////////////////////////////////
	// Parallel code tracking and soft-start

	localparam int SS_W = $clog2(SS_STEPS + 1);
	logic [CODE_W-1:0] code_r;
	logic chg_r;
	logic [SS_W-1:0] ss_cnt_r;
	logic [VREF_W-1:0] core_vref_r;
	logic [VREF_W-1:0] core_vref_nxt;
	wire logic par_start = en_rise & code_bit1_type_select;
	wire logic code_diff = is_par & (code_s != code_r);
	wire logic [VREF_W-1:0] par_target = par_code_volt(code_r);
	wire logic [VREF_W-1:0] ss_ramp = VREF_W'((32'(par_target) * 32'(ss_cnt_r))
		/ SS_STEPS);
	wire logic ss_run = (ss_cnt_r != SS_W'(SS_STEPS));

	always_comb begin
		core_vref_nxt = '0;
		if (is_par)
			core_vref_nxt = ss_run ? ss_ramp : par_target;
		else if (is_fix)
			core_vref_nxt = fix_volt({serial_scl, serial_data_line});
		else if (is_ser)
			core_vref_nxt = core_vref_r;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			code_r <= '0;
			chg_r <= 1'b0;
			ss_cnt_r <= '0;
			core_vref_r <= '0;
		end else begin
			chg_r <= code_diff;
			if (par_start | code_diff)
				code_r <= code_s;
			if (par_start)
				ss_cnt_r <= '0;
			else if (is_par & ss_run)
				ss_cnt_r <= ss_cnt_r + SS_W'(1);
			if (is_ser & serial_byte_valid & serial_core_addr)
				core_vref_r <= par_code_volt(serial_byte[5:0]);
			else
				core_vref_r <= core_vref_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Serial lines and low-power flag

	logic lpf_n_r;
	logic [VREF_W-1:0] north_vref_r;
	wire logic ser_like = is_ser | is_fix;
	// bits 0, 4 and 5 are not used outside parallel mode
	assign serial_scl = ser_like & code_s[SCL_BIT];
	assign serial_data_line = ser_like & code_s[SDA_BIT];
	assign serial_en = is_ser;
	assign serial_cmd_en = is_ser & pok_s;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			lpf_n_r <= SERIAL_BYTE_RESET[LPF_BIT];
			north_vref_r <= '0;
		end else begin
			if (!is_ser)
				lpf_n_r <= 1'b1;
			else if (serial_byte_valid & serial_cmd_en)
				lpf_n_r <= serial_byte[LPF_BIT];
			if (is_fix)
				north_vref_r <= fix_volt({serial_scl, serial_data_line});
			else if (is_ser & serial_byte_valid & serial_north_addr)
				north_vref_r <= par_code_volt(serial_byte[5:0]);
			else if (!is_ser)
				north_vref_r <= '0;
		end
	end

	wire logic low_power_flag_n = lpf_n_r;

	////////////////////////////////////////////////////////////////////////
	// Phase management and applied settings

	logic [2:0] phases_r;
	logic [1:0] north_slot_r;
	logic [7:0] freq_r;
	logic [7:0] ovp_r;
	logic [VREF_W-1:0] off_r;
	wire logic [2:0] cfg_ph = clamp_ph(core_phase_cfg);
	wire logic [2:0] shed_ph = (load_phase_need < cfg_ph) ? clamp_ph(load_phase_need) : cfg_ph;
	wire logic [2:0] base_ph = dynamic_phase_shedding ? shed_ph : cfg_ph;
	wire logic [2:0] ph_nxt = !low_power_flag_n ? PH_LOW : base_ph;
	wire logic north_on = ser_like & (north_vref_r != '0);

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			phases_r <= PH_RESET;
			north_slot_r <= NORTH_SHIFT_RESET;
			freq_r <= '0;
			ovp_r <= '0;
			off_r <= '0;
		end else begin
			phases_r <= ph_nxt;
			north_slot_r <= 2'(ph_nxt >> 1);
			freq_r <= freq_cfg;
			ovp_r <= ovp_cfg;
			off_r <= offset_cfg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign if_mode = mode_r;
	assign core_vref = VREF_W'(core_vref_r + off_r);
	assign north_vref = north_on ? VREF_W'(north_vref_r + off_r) : '0;
	assign core_ss_active = is_par & ss_run;
	assign code_changed = chg_r;
	assign core_phases = phases_r;
	assign low_power_active = ~lpf_n_r;
	assign freq_out = freq_r;
	assign ovp_out = ovp_r;
	// parallel mode leaves the northbridge stage off
	assign north_drive.hs_on = north_on;
	assign north_drive.ls_on = north_on;
	assign north_drive.switching = north_on;
	assign north_drive.phase_slot = north_on ? north_slot_r : 2'h0;
endmodule // cpu_type_detect

// ### bench/cpu_type_detect_props.sv
// Port checker for the processor interface selector.
// Assumes it is bound onto cpu_type_detect; one clock domain.
`timescale 1ns/1ns
module cpu_type_detect_props
	import type_detect_pkg::*;
(
	input wire logic core_clk, // Core clock
	input wire logic rst_b, // Sync reset, active low
	input wire logic [7:0] freq_cfg, // Frequency setting
	input wire logic [7:0] ovp_cfg, // Overvoltage setting
	input wire logic [1:0] if_mode, // Latched mode
	input wire logic [VREF_W-1:0] north_vref, // Northbridge reference
	input wire logic core_ss_active, // Soft-start running
	input wire logic serial_scl, // Serial clock line
	input wire logic serial_data_line, // Serial data line
	input wire logic serial_en, // Receiver on
	input wire logic serial_cmd_en, // Commands honoured
	input wire north_drive_t north_drive, // Northbridge switches
	input wire logic [2:0] core_phases, // Active phases
	input wire logic low_power_active, // Low-power state
	input wire logic [7:0] freq_out, // Applied frequency
	input wire logic [7:0] ovp_out // Applied threshold
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	chk_north_off_par: assert property (if_mode == MODE_PAR
		|-> north_drive == '0 && north_vref == '0)
		else $error("northbridge active in parallel mode");
	chk_mode_held: assert property ($past(if_mode) != MODE_IDLE && if_mode != MODE_IDLE
		|-> $stable(if_mode))
		else $error("mode changed without enable rise");
	chk_par_lines: assert property (if_mode == MODE_PAR
		|-> !serial_scl && !serial_data_line)
		else $error("serial lines live in parallel mode");
	chk_serial_sel: assert property (serial_en == (if_mode == MODE_SER))
		else $error("serial receiver enable wrong");
	chk_cmd_gate: assert property (serial_cmd_en |-> serial_en)
		else $error("commands honoured outside serial mode");
	chk_ss_par: assert property (core_ss_active |-> if_mode == MODE_PAR)
		else $error("soft-start outside parallel mode");
	chk_low_phase: assert property ($past(low_power_active) && low_power_active
		|-> core_phases == PH_LOW)
		else $error("low-power phase count wrong");
	chk_phase_range: assert property (!$past(low_power_active) && !low_power_active
		|-> core_phases inside {[PH_MIN:PH_MAX]})
		else $error("core phase count out of range");
	chk_live_cfg: assert property ($past(rst_b)
		|-> freq_out == $past(freq_cfg) && ovp_out == $past(ovp_cfg))
		else $error("live setting not applied");
endmodule // cpu_type_detect_props

bind cpu_type_detect cpu_type_detect_props u_cpu_type_detect_props (.core_clk(core_clk),
	.rst_b(rst_b), .freq_cfg(freq_cfg), .ovp_cfg(ovp_cfg), .if_mode(if_mode),
	.north_vref(north_vref), .core_ss_active(core_ss_active), .serial_scl(serial_scl),
	.serial_en(serial_en), .serial_data_line(serial_data_line), .serial_cmd_en(serial_cmd_en),
	.north_drive(north_drive), .core_phases(core_phases), .low_power_active(low_power_active),
	.freq_out(freq_out), .ovp_out(ovp_out));

// ### bench/cpu_side_model.sv
// Processor side: enable, code lines, power ok and received serial bytes.
// Assumes its tasks are called from the bench; it drives at falling edges.
`timescale 1ns/1ns
module cpu_side_model
	import type_detect_pkg::*;
(
	input wire logic core_clk, // Core clock
	output logic enable_pin, // Controller enable
	output logic [CODE_W-1:0] voltage_code_bus, // Code lines
	output logic power_ok_input, // Power ok
	output logic [7:0] serial_byte, // Received byte
	output logic serial_byte_valid, // Byte strobe
	output logic serial_core_addr, // Core addressed
	output logic serial_north_addr // Northbridge addressed
);
	initial begin
		enable_pin = 1'b0;
		voltage_code_bus = '0;
		power_ok_input = 1'b0;
		serial_byte = 8'hA5;
		serial_byte_valid = 1'b0;
		serial_core_addr = 1'b0;
		serial_north_addr = 1'b0;
	end
	// Level changes on the code lines and power ok, made by the caller at a falling edge
	task automatic set_code(input logic [CODE_W-1:0] code);
		voltage_code_bus = code;
	endtask
	task automatic set_pok(input logic level);
		power_ok_input = level;
	endtask
	// Code lines settle before enable rises so the type is read right
	task automatic power_up(input logic [5:0] code);
		@(negedge core_clk) enable_pin = 1'b0;
		repeat (8) @(negedge core_clk);
		voltage_code_bus = code;
		repeat (3) @(negedge core_clk);
		enable_pin = 1'b1;
		repeat (10) @(negedge core_clk);
	endtask
	task automatic send(input logic lpf_n, input logic [6:0] code);
		@(negedge core_clk);
		serial_byte = {lpf_n, code};
		serial_byte_valid = 1'b1;
		serial_core_addr = 1'b1;
		serial_north_addr = 1'b1;
		@(negedge core_clk);
		serial_byte_valid = 1'b0;
		serial_byte = ~serial_byte;
		repeat (8) @(negedge core_clk);
	endtask
endmodule // cpu_side_model

// ### bench/tb.sv
// Self-checking bench for the processor interface selector.
// Assumes the design, package, checker and processor model are compiled first.
`timescale 1ns/1ns
module tb;
	import type_detect_pkg::*;
	logic core_clk, rst_b, fix_mode_pin, dynamic_phase_shedding;
	logic [2:0] core_phase_cfg, load_phase_need;
	logic [VREF_W-1:0] offset_cfg;
	logic [7:0] freq_cfg, ovp_cfg;
	int errors = 0;
	int cmp_count = 0;
	wire logic enable_pin, power_ok_input, serial_byte_valid, serial_core_addr, serial_north_addr;
	wire logic [CODE_W-1:0] voltage_code_bus;
	wire logic [7:0] serial_byte;
	cpu_type_detect #(.SS_STEPS(4)) u_cpu_type_detect (.core_clk(core_clk), .rst_b(rst_b),
		.enable_pin(enable_pin), .fix_mode_pin(fix_mode_pin),
		.voltage_code_bus(voltage_code_bus), .power_ok_input(power_ok_input),
		.serial_byte(serial_byte), .serial_byte_valid(serial_byte_valid),
		.serial_core_addr(serial_core_addr), .serial_north_addr(serial_north_addr),
		.core_phase_cfg(core_phase_cfg), .dynamic_phase_shedding(dynamic_phase_shedding),
		.load_phase_need(load_phase_need), .offset_cfg(offset_cfg), .freq_cfg(freq_cfg),
		.ovp_cfg(ovp_cfg), .if_mode(), .core_vref(), .north_vref(), .core_ss_active(),
		.code_changed(), .serial_scl(), .serial_data_line(), .serial_en(), .serial_cmd_en(),
		.north_drive(), .core_phases(), .low_power_active(), .freq_out(), .ovp_out());
	cpu_side_model m (.core_clk(core_clk), .enable_pin(enable_pin),
		.voltage_code_bus(voltage_code_bus), .power_ok_input(power_ok_input),
		.serial_byte(serial_byte), .serial_byte_valid(serial_byte_valid),
		.serial_core_addr(serial_core_addr), .serial_north_addr(serial_north_addr));
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic settle();
		repeat (12) @(negedge core_clk);
	endtask
	function automatic logic [14:0] par_v(input logic [5:0] c);
		return c[5] ? LO_BASE_UV - LO_STEP_UV * c[4:0] : HI_BASE_UV - HI_STEP_UV * c[4:0];
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_par();
		logic [5:0] codes [5] = '{6'h02, 6'h00, 6'h1F, 6'h20, 6'h3F};
		logic seen;
		m.power_up(6'h02);
		chk("mode", MODE_PAR, u_cpu_type_detect.if_mode);
		chk("ss_done", 1'b0, u_cpu_type_detect.core_ss_active);
		chk("vref_start", par_v(6'h02), u_cpu_type_detect.core_vref);
		foreach (codes[i]) begin
			m.set_code(codes[i]);
			seen = 1'b0;
			repeat (12) begin
				@(negedge core_clk);
				seen = seen | u_cpu_type_detect.code_changed;
			end
			chk("code_changed", i != 0, seen);
			chk("core_vref", par_v(codes[i]), u_cpu_type_detect.core_vref);
		end
		chk("mode_held", MODE_PAR, u_cpu_type_detect.if_mode);
		m.set_pok(1'b1);
		m.send(1'b0, 7'h10);
		chk("vref_pok", par_v(6'h3F), u_cpu_type_detect.core_vref);
		chk("lp_par", 1'b0, u_cpu_type_detect.low_power_active);
		offset_cfg = 15'h0064;
		settle();
		chk("vref_offset", par_v(6'h3F) + 15'h0064, u_cpu_type_detect.core_vref);
		offset_cfg = '0;
		m.set_pok(1'b0);
		$display("test parallel done");
	endtask
	task automatic t_ser();
		m.power_up(6'h0C);
		chk("mode", MODE_SER, u_cpu_type_detect.if_mode);
		chk("freq_live", 8'h3C, u_cpu_type_detect.freq_out);
		chk("ovp_live", 8'hC3, u_cpu_type_detect.ovp_out);
		m.set_code(6'h3D);
		settle();
		chk("lines", 2'h3,
			{u_cpu_type_detect.serial_scl, u_cpu_type_detect.serial_data_line});
		m.send(1'b0, 7'h10);
		chk("lp_refused", 1'b0, u_cpu_type_detect.low_power_active);
		chk("north_slot_set", 1'b1,
			u_cpu_type_detect.north_drive.phase_slot != 2'h0);
		m.set_pok(1'b1);
		settle();
		m.send(1'b0, 7'h10);
		chk("lp_on", 1'b1, u_cpu_type_detect.low_power_active);
		chk("phases_lp", PH_LOW, u_cpu_type_detect.core_phases);
		chk("ser_vref", par_v(6'h10), u_cpu_type_detect.core_vref);
		m.send(1'b1, 7'h10);
		chk("phases_cfg", 3'h3, u_cpu_type_detect.core_phases);
		dynamic_phase_shedding = 1'b1;
		settle();
		chk("phases_shed", 3'h2, u_cpu_type_detect.core_phases);
		dynamic_phase_shedding = 1'b0;
		m.set_pok(1'b0);
		$display("test serial done");
	endtask
	task automatic t_fix();
		logic [14:0] fx [4] = '{FIX_V0, FIX_V1, FIX_V2, FIX_V3};
		fix_mode_pin = 1'b1;
		m.set_pok(1'b1);
		for (int i = 0; i < 4; i++) begin
			m.power_up({2'h0, i[1:0], 2'h0});
			m.send(1'b0, 7'h00);
			chk("mode", MODE_FIX, u_cpu_type_detect.if_mode);
			chk("lp_fix", 1'b0, u_cpu_type_detect.low_power_active);
			chk("north_fix", fx[i], u_cpu_type_detect.north_vref);
			chk("core_fix", fx[i], u_cpu_type_detect.core_vref);
		end
		fix_mode_pin = 1'b0;
		$display("test fixed done");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("checks %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		rst_b = 1'b0;
		fix_mode_pin = 1'b0;
		dynamic_phase_shedding = 1'b0;
		core_phase_cfg = 3'h3;
		load_phase_need = 3'h2;
		offset_cfg = '0;
		freq_cfg = 8'h5A;
		ovp_cfg = 8'hC3;
		repeat (20) @(negedge core_clk);
		rst_b = 1'b1;
		t_par();
		freq_cfg = 8'h3C;
		t_ser();
		t_fix();
		end_sim();
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		errors++;
		$display("mismatch watchdog expected done seen hang");
		end_sim();
	end
endmodule // tb
